//--- rtl/aft_top.sv
`timescale 1ns/100ps
`include "aft_params.svh"

module aft_top #(
  parameter int SETTLE_CYC = `AFT_SETTLE_CYC,
  parameter aft_pkg::aft_level_t PHASE_TOL = `AFT_PHASE_TOL
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic spi_ss_n,
  input wire logic am_demod,
  input wire logic pm_demod,
  input wire logic cmd_transparent,
  input wire logic cmd_calibrate_antenna,
  input wire logic spi_miso_norm,
  input wire logic spi_miso_oe_norm,
  input wire logic irq_norm,
  input wire logic tx_mod_norm,
  input wire logic rx_on_norm,
  input wire logic rx_am_en,
  input wire logic rx_pm_en,
  input wire aft_pkg::aft_level_t mod_depth_ctrl,
  input wire aft_pkg::aft_level_t am_level_reg,
  input wire aft_pkg::aft_level_t cal_mod_level,
  input wire logic trim_manual_sel,
  input wire aft_pkg::aft_trim_t trim_manual,
  input wire aft_pkg::aft_level_t trim_target_phase,
  input wire logic meas_done,
  input wire aft_pkg::aft_level_t meas_result,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic irq,
  output logic tx_modulate,
  output logic rx_on,
  output logic spi_core_en,
  output logic framing_bypass,
  output logic transparent_active,
  output aft_pkg::aft_level_t am_modulated_level,
  output logic meas_phase_req,
  output logic meas_ampl_req,
  output aft_pkg::aft_trim_t trim_switch_side_one,
  output aft_pkg::aft_trim_t trim_switch_side_two,
  output aft_pkg::aft_trim_t trim_cal_result,
  output logic trim_cal_error,
  output logic trim_cal_busy,
  output logic trim_cal_done
);
  import aft_pkg::*;

  localparam int CNT_W = $clog2(SETTLE_CYC + 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

  // ========================================================
  // State
  typedef struct packed {
    logic armed;
    logic transparent;
    logic ss_n_d;
    logic spi_core_en;
    logic framing_bypass;
    aft_level_t am_level;
    aft_cal_state_t cal_st;
    aft_trim_t sweep;
    aft_trim_t best;
    aft_level_t best_dist;
    aft_level_t best_ampl;
    aft_level_t cur_dist;
    logic [CNT_W-1:0] cnt;
    logic phase_req;
    logic ampl_req;
    logic busy;
    logic done;
    logic err;
    aft_trim_t result;
    aft_trim_t trim;
  } aft_top_st_t;

  aft_top_st_t st_r;
  aft_top_st_t st_nxt;

  logic [4:0] sync_q;
  logic sclk_s;
  logic mosi_s;
  logic ss_n_s;
  logic am_dmd_s;
  logic pm_s;
  logic ss_rise;
  logic ss_fall;
  logic better;

  function automatic aft_level_t abs_diff(
    input aft_level_t a,
    input aft_level_t b
  );
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  // ========================================================
  // Pin synchronisers
  // Demod outputs are async too, so they share the chain
  aft_sync #(
    .W(5)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .d({spi_sclk, spi_mosi, spi_ss_n, am_demod, pm_demod}),
    .q(sync_q)
  );

  assign sclk_s = sync_q[4];
  assign mosi_s = sync_q[3];
  assign ss_n_s = sync_q[2];
  assign am_dmd_s = sync_q[1];
  assign pm_s = sync_q[0];
  assign ss_rise = ss_n_s && !st_r.ss_n_d;
  assign ss_fall = !ss_n_s && st_r.ss_n_d;

  // Unsigned distance: the phase code does not wrap
  // Phase first; ties broken by larger amplitude
  assign better = (st_r.cur_dist < st_r.best_dist) ||
                  ((st_r.cur_dist == st_r.best_dist) &&
                   (meas_result > st_r.best_ampl));

  // ========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.phase_req = 1'b0;
    st_nxt.ampl_req = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.ss_n_d = ss_n_s;

    // Command only arms; entry waits for select release
    if (cmd_transparent) begin
      st_nxt.armed = 1'b1;
    end
    if (ss_rise && st_r.armed) begin
      st_nxt.transparent = 1'b1;
      st_nxt.armed = 1'b0;
    end
    if (ss_fall) begin
      st_nxt.transparent = 1'b0;
    end
    // Core held off while the pins are borrowed
    st_nxt.spi_core_en = !st_nxt.transparent;
    st_nxt.framing_bypass = st_nxt.transparent;

    if (mod_depth_ctrl[`AFT_MOD_SRC_BIT]) begin
      st_nxt.am_level = am_level_reg;
    end else begin
      st_nxt.am_level = cal_mod_level;
    end

    // Exhaustive sweep: 16 codes, no local minimum trap
    unique case (st_r.cal_st)
      CAL_IDLE: begin
        if (cmd_calibrate_antenna) begin
          st_nxt.busy = 1'b1;
          st_nxt.sweep = `AFT_TRIM_RST;
          st_nxt.best = `AFT_TRIM_RST;
          st_nxt.best_dist = `AFT_DIST_INIT;
          st_nxt.best_ampl = `AFT_LEVEL_RST;
          st_nxt.cnt = '0;
          st_nxt.cal_st = CAL_SETTLE;
        end
      end
      CAL_SETTLE: begin
        if (st_r.cnt == SETTLE_LAST) begin
          st_nxt.cnt = '0;
          st_nxt.phase_req = 1'b1;
          st_nxt.cal_st = CAL_PHASE;
        end else begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end
      CAL_PHASE: begin
        if (meas_done) begin
          // Raw compare: same code as phase result
          st_nxt.cur_dist =
            abs_diff(meas_result, trim_target_phase);
          st_nxt.ampl_req = 1'b1;
          st_nxt.cal_st = CAL_AMPL;
        end
      end
      CAL_AMPL: begin
        if (meas_done) begin
          if (better) begin
            st_nxt.best = st_r.sweep;
            st_nxt.best_dist = st_r.cur_dist;
            st_nxt.best_ampl = meas_result;
          end
          st_nxt.cal_st = CAL_NEXT;
        end
      end
      CAL_NEXT: begin
        if (st_r.sweep == 4'hf) begin
          st_nxt.result = st_r.best;
          st_nxt.err = st_r.best_dist > PHASE_TOL;
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
          st_nxt.cal_st = CAL_IDLE;
        end else begin
          st_nxt.sweep = st_r.sweep + 1'b1;
          st_nxt.cal_st = CAL_SETTLE;
        end
      end
      default: begin
        // Stray state code: abandon the sweep, trim falls back
        st_nxt.busy = 1'b0;
        st_nxt.cal_st = CAL_IDLE;
      end
    endcase

    if (st_nxt.busy) begin
      st_nxt.trim = st_nxt.sweep;
    end else if (trim_manual_sel) begin
      st_nxt.trim = trim_manual;
    end else begin
      st_nxt.trim = st_nxt.result;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.cal_st <= CAL_IDLE;
      st_r.spi_core_en <= 1'b1;
      // Rise seen just after reset is harmless unless armed
      st_r.ss_n_d <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ========================================================
  // Transparent pin routing
  aft_pin_if pin_if ();

  assign pin_if.transparent = st_r.transparent;
  assign pin_if.mosi = mosi_s;
  assign pin_if.sclk = sclk_s;
  assign pin_if.am = am_dmd_s;
  // Channel enables are register bits on this clock: no sync
  assign pin_if.pm = pm_s;
  assign pin_if.am_en = rx_am_en;
  assign pin_if.pm_en = rx_pm_en;
  assign pin_if.miso_norm = spi_miso_norm;
  assign pin_if.miso_oe_norm = spi_miso_oe_norm;
  assign pin_if.irq_norm = irq_norm;
  assign pin_if.tx_norm = tx_mod_norm;
  assign pin_if.rx_on_norm = rx_on_norm;

  aft_pin_mux u_mux (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .p(pin_if.mux)
  );

  // ========================================================
  // Outputs
  assign spi_miso = pin_if.miso;
  assign spi_miso_oe = pin_if.miso_oe;
  assign irq = pin_if.irq;
  assign tx_modulate = pin_if.tx_mod;
  assign rx_on = pin_if.rx_on;
  assign spi_core_en = st_r.spi_core_en;
  assign framing_bypass = st_r.framing_bypass;
  assign transparent_active = st_r.transparent;
  assign am_modulated_level = st_r.am_level;
  assign meas_phase_req = st_r.phase_req;
  assign meas_ampl_req = st_r.ampl_req;
  // Both sides from one register
  assign trim_switch_side_one = st_r.trim;
  assign trim_switch_side_two = st_r.trim;
  assign trim_cal_result = st_r.result;
  assign trim_cal_error = st_r.err;
  assign trim_cal_busy = st_r.busy;
  assign trim_cal_done = st_r.done;
endmodule // aft_top

//--- rtl/aft_params.svh
`ifndef AFT_PARAMS_SVH
`define AFT_PARAMS_SVH

// ==========================================================
// Field positions
`define AFT_MOD_SRC_BIT 7

// ==========================================================
// Widths
`define AFT_TRIM_W 4
`define AFT_MEAS_W 8

// ==========================================================
// Reset values
`define AFT_LEVEL_RST 8'h00
`define AFT_TRIM_RST 4'h0
`define AFT_DIST_INIT 8'hff

// ==========================================================
// Timing
`define AFT_CLK_HZ 50000000
`define AFT_SETTLE_NS 2000
// Least time, so round up
`define AFT_SETTLE_CYC \
  ((`AFT_SETTLE_NS * (`AFT_CLK_HZ / 1000000) + 999) / 1000)

// ==========================================================
// Tuning tolerance on phase distance
`define AFT_PHASE_TOL 8'h08

`endif

//--- rtl/aft_pkg.sv
package aft_pkg;

  typedef logic [7:0] aft_level_t;
  typedef logic [3:0] aft_trim_t;

  typedef enum logic [4:0] {
    CAL_IDLE   = 5'b00001,
    CAL_SETTLE = 5'b00010,
    CAL_PHASE  = 5'b00100,
    CAL_AMPL   = 5'b01000,
    CAL_NEXT   = 5'b10000
  } aft_cal_state_t;

endpackage

//--- rtl/aft_pin_if.sv
`timescale 1ns/100ps
interface aft_pin_if;
  logic transparent;
  logic mosi;
  logic sclk;
  logic am;
  logic pm;
  logic am_en;
  logic pm_en;
  logic miso_norm;
  logic miso_oe_norm;
  logic irq_norm;
  logic tx_norm;
  logic rx_on_norm;
  logic miso;
  logic miso_oe;
  logic irq;
  logic tx_mod;
  logic rx_on;

  modport ctl (
    output transparent, mosi, sclk, am, pm, am_en, pm_en,
    output miso_norm, miso_oe_norm, irq_norm, tx_norm, rx_on_norm,
    input miso, miso_oe, irq, tx_mod, rx_on
  );
  modport mux (
    input transparent, mosi, sclk, am, pm, am_en, pm_en,
    input miso_norm, miso_oe_norm, irq_norm, tx_norm, rx_on_norm,
    output miso, miso_oe, irq, tx_mod, rx_on
  );
endinterface

//--- rtl/aft_sync.sv
`timescale 1ns/100ps
module aft_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import aft_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } aft_sync_st_t;

  aft_sync_st_t st_r;
  aft_sync_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = d;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.stable;
endmodule // aft_sync

//--- rtl/aft_pin_mux.sv
`timescale 1ns/100ps
module aft_pin_mux (
  input wire logic clk_sys,
  input wire logic resetn,
  aft_pin_if.mux p
);
  import aft_pkg::*;

  typedef struct packed {
    logic miso;
    logic miso_oe;
    logic irq;
    logic tx_mod;
    logic rx_on;
  } aft_mux_st_t;

  aft_mux_st_t st_r;
  aft_mux_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (p.transparent) begin
      st_nxt.tx_mod = p.mosi;
      st_nxt.rx_on = p.sclk;
      st_nxt.miso_oe = 1'b1;
      if (p.am_en && p.pm_en) begin
        st_nxt.miso = p.am;
        st_nxt.irq = p.pm;
      end else if (p.pm_en) begin
        st_nxt.miso = p.pm;
        st_nxt.irq = 1'b0;
      end else begin
        st_nxt.miso = p.am;
        st_nxt.irq = 1'b0;
      end
    end else begin
      // Normal pin functions come back on the next clock
      st_nxt.tx_mod = p.tx_norm;
      st_nxt.rx_on = p.rx_on_norm;
      st_nxt.miso = p.miso_norm;
      st_nxt.miso_oe = p.miso_oe_norm;
      st_nxt.irq = p.irq_norm;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign p.miso = st_r.miso;
  assign p.miso_oe = st_r.miso_oe;
  assign p.irq = st_r.irq;
  assign p.tx_mod = st_r.tx_mod;
  assign p.rx_on = st_r.rx_on;
endmodule // aft_pin_mux

//--- tb/aft_sva.sv
`timescale 1ns/100ps
// ====================
// Port checker
module aft_sva (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic spi_ss_n,
  input wire logic am_demod,
  input wire logic pm_demod,
  input wire logic tx_mod_norm,
  input wire logic rx_am_en,
  input wire logic rx_pm_en,
  input wire aft_pkg::aft_level_t mod_depth_ctrl,
  input wire aft_pkg::aft_level_t am_level_reg,
  input wire aft_pkg::aft_level_t cal_mod_level,
  input wire logic trim_manual_sel,
  input wire aft_pkg::aft_trim_t trim_manual,
  input wire logic spi_miso,
  input wire logic irq,
  input wire logic tx_modulate,
  input wire logic rx_on,
  input wire logic spi_core_en,
  input wire logic framing_bypass,
  input wire logic transparent_active,
  input wire aft_pkg::aft_level_t am_modulated_level,
  input wire aft_pkg::aft_trim_t trim_switch_side_one,
  input wire aft_pkg::aft_trim_t trim_switch_side_two,
  input wire logic trim_cal_busy,
  input wire logic trim_cal_done
);
  import aft_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_lvl;
    $past(resetn) |-> am_modulated_level == ($past(mod_depth_ctrl[7])
      ? $past(am_level_reg) : $past(cal_mod_level));
  endproperty
  a_lvl: assert property (p_lvl) else $error("level source");
  property p_trim;
    trim_switch_side_one == trim_switch_side_two;
  endproperty
  a_trim: assert property (p_trim) else $error("trim sides differ");
  property p_man;
    $past(resetn) && !trim_cal_busy && !$past(trim_cal_busy)
      && $past(trim_manual_sel) |-> trim_switch_side_one == $past(trim_manual);
  endproperty
  a_man: assert property (p_man) else $error("manual trim");
  property p_sweep;
    $rose(trim_cal_busy) |-> trim_switch_side_one == 4'h0;
  endproperty
  a_sweep: assert property (p_sweep) else $error("sweep start");
  property p_tx;
    transparent_active && $past(transparent_active)
      |-> tx_modulate == $past(spi_mosi, 3) && rx_on == $past(spi_sclk, 3);
  endproperty
  a_tx: assert property (p_tx) else $error("modulator or gate");
  // Enable changes need three quiet cycles before outputs are judged
  property p_out;
    transparent_active && $past(transparent_active)
      && rx_am_en == $past(rx_am_en, 3) && rx_pm_en == $past(rx_pm_en, 3)
      |-> spi_miso == ((rx_pm_en && !rx_am_en) ? $past(pm_demod, 3)
      : $past(am_demod, 3)) && irq == (rx_am_en && rx_pm_en
      && $past(pm_demod, 3));
  endproperty
  a_out: assert property (p_out) else $error("demod routing");
  property p_in;
    transparent_active |-> $past(spi_ss_n, 3);
  endproperty
  a_in: assert property (p_in) else $error("entry");
  property p_exit;
    $fell(spi_ss_n) && transparent_active
      |-> ##3 !transparent_active && spi_core_en;
  endproperty
  a_exit: assert property (p_exit) else $error("exit");
  property p_cfg;
    framing_bypass == transparent_active && spi_core_en == !transparent_active;
  endproperty
  a_cfg: assert property (p_cfg) else $error("framing bypass");
  property p_norm;
    $past(resetn) && !transparent_active && !$past(transparent_active)
      |-> tx_modulate == $past(tx_mod_norm);
  endproperty
  a_norm: assert property (p_norm) else $error("normal pins");
  c_in: cover property (transparent_active && rx_am_en && rx_pm_en);
  c_out: cover property ($fell(transparent_active));
  c_cal: cover property (trim_cal_done);
endmodule // aft_sva
bind aft_top aft_sva u_sva (.*);

//--- tb/aft_host.sv
`timescale 1ns/100ps
// ====================
// Host controller on the serial pins
module aft_host (
  input wire logic clk_sys,
  output logic spi_sclk,
  output logic spi_mosi,
  output logic spi_ss_n
);
  initial begin
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
    spi_ss_n = 1'b1;
  end
  // Front end already set up by the bench before any command
  task select(input logic v);
    @(negedge clk_sys);
    spi_ss_n = v;
  endtask
  // Serial clock stands low between frames; data inverted when done
  task shift(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk_sys);
      spi_mosi = b[i];
      spi_sclk = 1'b1;
      repeat (4) @(negedge clk_sys);
      spi_sclk = 1'b0;
      repeat (3) @(negedge clk_sys);
    end
    @(negedge clk_sys);
    spi_mosi = ~b[0];
  endtask
endmodule // aft_host

//--- tb/tb_aft_top.sv
`timescale 1ns/100ps
// ====================
// Bench
module tb_aft_top;
  import aft_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0;
  logic spi_sclk, spi_mosi, spi_ss_n;
  logic am_demod = 1'b0, pm_demod = 1'b0, cmd_transparent = 1'b0;
  logic cmd_calibrate_antenna = 1'b0, spi_miso_norm = 1'b0;
  logic spi_miso_oe_norm = 1'b0, irq_norm = 1'b1, tx_mod_norm = 1'b0;
  logic rx_on_norm = 1'b0, rx_am_en = 1'b1, rx_pm_en = 1'b1;
  aft_level_t mod_depth_ctrl = 8'h00, am_level_reg = 8'h00;
  aft_level_t cal_mod_level = 8'h00, trim_target_phase = 8'h00;
  aft_level_t meas_result = 8'h00, am_modulated_level;
  logic trim_manual_sel = 1'b0, meas_done = 1'b0;
  aft_trim_t trim_manual = 4'h0, trim_switch_side_one, trim_switch_side_two;
  aft_trim_t trim_cal_result;
  logic spi_miso, spi_miso_oe, irq, tx_modulate, rx_on, spi_core_en;
  logic framing_bypass, transparent_active, meas_phase_req, meas_ampl_req;
  logic trim_cal_error, trim_cal_busy, trim_cal_done;
  int fails = 0, compares = 0;

  aft_top #(.SETTLE_CYC(2)) DUT (.*);
  aft_host host (.*);

  always #10 clk_sys = ~clk_sys;

  // Phase rises 4 codes per trim step, so only one code is nearest
  always @(negedge clk_sys) begin
    meas_done <= meas_phase_req || meas_ampl_req;
    meas_result <= meas_phase_req
      ? 8'h30 + {2'h0, trim_switch_side_one, 2'h0} : 8'h10;
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task t_level;
    @(negedge clk_sys);
    am_level_reg = 8'h5a;
    cal_mod_level = 8'h21;
    mod_depth_ctrl = 8'h80;
    repeat (2) @(negedge clk_sys);
    chk(am_modulated_level, 8'h5a, "host level");
    mod_depth_ctrl = 8'h7e;
    repeat (2) @(negedge clk_sys);
    chk(am_modulated_level, 8'h21, "cal level");
    $display("level test done");
  endtask

  // Front-end amplitude against normal level, as the host sees it
  function automatic aft_level_t afe_ampl(input aft_level_t lvl);
    afe_ampl = 8'hc0 - {1'b0, lvl[7:1]} - {2'b0, lvl[7:2]};
  endfunction

  // Deep modulation: host runs the level search itself
  task t_host_cal;
    aft_level_t norm_lvl, full, tgt, best, best_d, got, d;
    norm_lvl = 8'h00;
    full = afe_ampl(norm_lvl);
    tgt = {2'h0, full[7:2]};
    best = 8'h00;
    best_d = 8'hff;
    for (int l = 0; l < 256; l++) begin
      norm_lvl = 8'(l);
      got = afe_ampl(norm_lvl);
      d = (got > tgt) ? got - tgt : tgt - got;
      if (d < best_d) begin
        best_d = d;
        best = norm_lvl;
      end
    end
    @(negedge clk_sys);
    am_level_reg = best;
    mod_depth_ctrl = 8'h80;
    norm_lvl = 8'h00;
    repeat (2) @(negedge clk_sys);
    chk(am_modulated_level, 8'hc0, "host cal level");
    $display("host calibration test done");
  endtask

  task t_trim;
    trim_manual = 4'ha;
    trim_manual_sel = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(8'(trim_switch_side_one), 8'h0a, "manual one");
    chk(8'(trim_switch_side_two), 8'h0a, "manual two");
    trim_manual_sel = 1'b0;
    $display("trim test done");
  endtask

  task t_cal(input aft_level_t tgt, input aft_trim_t code, input logic err);
    int n;
    n = 0;
    trim_target_phase = tgt;
    cmd_calibrate_antenna = 1'b1;
    @(negedge clk_sys);
    cmd_calibrate_antenna = 1'b0;
    @(negedge clk_sys);
    chk(8'(trim_cal_busy), 8'h01, "busy");
    while (trim_cal_done !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    chk({6'h0, trim_cal_done, trim_cal_error}, {7'h1, err}, "flag");
    chk(8'(trim_cal_result), 8'(code), "result");
    @(negedge clk_sys);
    chk(8'(trim_switch_side_one), 8'(code), "chosen");
    $display("calibration test done");
  endtask

  task t_trans;
    tx_mod_norm = 1'b1;
    rx_on_norm = 1'b1;
    host.select(1'b0);
    host.select(1'b1);
    repeat (6) @(negedge clk_sys);
    chk({5'h0, transparent_active, tx_modulate, rx_on}, 8'h03,
      "no arm");
    tx_mod_norm = 1'b0;
    host.select(1'b0);
    cmd_transparent = 1'b1;
    @(negedge clk_sys);
    cmd_transparent = 1'b0;
    host.select(1'b1);
    repeat (6) @(negedge clk_sys);
    chk({5'h0, transparent_active, spi_core_en, framing_bypass}, 8'h05,
      "enter");
    am_demod = 1'b1;
    host.shift(8'ha6);
    repeat (4) @(negedge clk_sys);
    chk({3'h0, spi_miso_oe, tx_modulate, rx_on, spi_miso, irq}, 8'h1a,
      "pins");
    am_demod = 1'b0;
    pm_demod = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk({6'h0, spi_miso, irq}, 8'h01, "pm on irq");
    rx_am_en = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk({6'h0, spi_miso, irq}, 8'h02, "pm alone");
    rx_am_en = 1'b1;
    rx_pm_en = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk({6'h0, spi_miso, irq}, 8'h00, "am alone");
    rx_pm_en = 1'b1;
    spi_miso_norm = 1'b1;
    spi_miso_oe_norm = 1'b1;
    irq_norm = 1'b0;
    host.select(1'b0);
    repeat (5) @(negedge clk_sys);
    chk({1'h0, transparent_active, spi_core_en, tx_modulate, rx_on,
      spi_miso_oe, spi_miso, irq}, 8'h2e, "exit");
    $display("transparent test done");
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    test_done;
  end

  initial begin
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    t_level;
    t_host_cal;
    t_trim;
    t_cal(8'h40, 4'h4, 1'b0);
    t_cal(8'hf0, 4'hf, 1'b1);
    t_trans;
    test_done;
  end
endmodule // tb_aft_top
